// file: event_recorder_pkg.sv
// Shared constants and types of the event recorder
package event_recorder_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_HZ         = 25_000_000;
  localparam int SCAN_US        = 125;
  localparam int SCAN_CYCLES    = (CLK_HZ / 1_000_000) * SCAN_US;
  localparam int DEBOUNCE_US    = 4000;
  // One extra scan so a pulse just under the limit can never reach it
  localparam int DEBOUNCE_SCANS = (DEBOUNCE_US + SCAN_US - 1) / SCAN_US + 1;
  localparam int TICK_MS        = 1;
  localparam int TICK_CYCLES    = (CLK_HZ / 1000) * TICK_MS;
  localparam int CHATTER_MS     = 100;
  localparam int CHATTER_COUNT  = 4;

  // ==========================================================================
  // Widths and sizes
  localparam int NUM_CH      = 16;
  localparam int ID_W        = 4;
  localparam int TIME_W      = 16;
  localparam int DATA_W      = 16;
  localparam int ADDR_W      = 7;
  localparam int BUF_EVENTS  = 32;
  localparam int BUF_WORDS   = 64;
  localparam int REC_W       = 2 * DATA_W;
  localparam int FIFO_DEPTH  = 2;

  // ==========================================================================
  // Register word addresses
  localparam logic [6:0] ADDR_MASK     = 7'h00;
  localparam logic [6:0] ADDR_CTRL     = 7'h01;
  localparam logic [6:0] ADDR_TIME     = 7'h02;
  localparam logic [6:0] ADDR_STATUS   = 7'h03;
  localparam logic [6:0] ADDR_CHATTER  = 7'h04;
  localparam logic [6:0] ADDR_INPUTS   = 7'h05;
  localparam logic [6:0] ADDR_BUF_BASE = 7'h40;

  // ==========================================================================
  // Field positions and reset values
  localparam int CTRL_POLICY_BIT = 0;
  localparam int STAT_OVF_BIT    = 8;
  localparam int STAT_BANK_BIT   = 9;
  localparam int ID_STATE_BIT    = 4;
  localparam int ID_CHAT_BIT     = 5;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] TIME_RST = 16'h0000;

  typedef logic [REC_W-1:0] record_t;

endpackage

// file: rec_stream_if.sv
// Valid/ready record stream between the recorder's own modules
`timescale 1ns/1ps
interface rec_stream_if #(parameter int W = 32);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // rec_stream_if

// file: rec_fifo.sv
// Small valid/ready FIFO holding event records
`timescale 1ns/1ps
module rec_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input wire logic   clk,   // System clock
  input wire logic   rst_n, // Async reset, active low
  rec_stream_if.snk  inp,   // Filling side
  rec_stream_if.src  outp   // Draining side
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad
    $error("rec_fifo needs DEPTH of at least two");
  end

  // ==========================================================================
  // Storage and pointers
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wrPtr_q, wrPtr_d;
  logic [PW-1:0]    rdPtr_q, rdPtr_d;
  logic [CW-1:0]    count_q, count_d;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // Honest full and empty straight from the occupancy count
  assign inp.ready  = (count_q != CW'(DEPTH));
  assign outp.valid = (count_q != '0);
  assign outp.data  = store[rdPtr_q];
  assign push       = inp.valid && inp.ready;
  assign pop        = outp.valid && outp.ready;

  // Pointer and count update
  always_comb begin
    wrPtr_d = push ? nextPtr(wrPtr_q) : wrPtr_q;
    rdPtr_d = pop ? nextPtr(rdPtr_q) : rdPtr_q;
    count_d = count_q;
    if (push && !pop) begin
      count_d = CW'(count_q + 1'b1);
    end else if (pop && !push) begin
      count_d = CW'(count_q - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // Data words need no reset
  always_ff @(posedge clk) begin
    if (push) begin
      store[wrPtr_q] <= inp.data;
    end
  end

endmodule // rec_fifo

// file: event_recorder_module.sv
// Sixteen-channel debounced event recorder with two alternating buffers
`timescale 1ns/1ps
module event_recorder_module #(
  parameter int NUM_CH      = event_recorder_pkg::NUM_CH,
  parameter int MS_CYCLES   = event_recorder_pkg::TICK_CYCLES,
  parameter int SCAN_CYCLES = event_recorder_pkg::SCAN_CYCLES
) (
  input  wire logic              sys_clk,   // System clock, 25 MHz
  input  wire logic              arst_n,    // Async reset, active low
  input  wire logic [NUM_CH-1:0] fieldIn,   // Field input states
  input  wire logic [6:0]        busAddr,   // Register word address
  input  wire logic [15:0]       busWrData, // Write data
  input  wire logic              busWr,     // Write strobe
  input  wire logic              busRd,     // Read strobe
  output logic      [15:0]       busRdData  // Read data, cycle after strobe
);
  localparam int MS_W  = $clog2(MS_CYCLES + 1);
  localparam int DEB_W = $clog2(event_recorder_pkg::DEBOUNCE_SCANS + 1);
  localparam int AGE_W = $clog2(event_recorder_pkg::CHATTER_MS + 1);
  localparam int CNT_W = $clog2(event_recorder_pkg::CHATTER_COUNT + 1);
  localparam int EV_W  = $clog2(event_recorder_pkg::BUF_EVENTS + 1);
  localparam int SC_W  = $clog2(SCAN_CYCLES);
  localparam logic [SC_W-1:0] SCAN_LAST = SC_W'(SCAN_CYCLES - 1);
  localparam logic [DEB_W-1:0] DEB_LIMIT =
    DEB_W'(event_recorder_pkg::DEBOUNCE_SCANS);
  localparam logic [AGE_W-1:0] AGE_LIMIT =
    AGE_W'(event_recorder_pkg::CHATTER_MS);
  localparam logic [CNT_W-1:0] CNT_LIMIT =
    CNT_W'(event_recorder_pkg::CHATTER_COUNT);
  localparam logic [EV_W-1:0] EV_LIMIT =
    EV_W'(event_recorder_pkg::BUF_EVENTS);

  if (NUM_CH < 1 || NUM_CH > 16 || MS_CYCLES < 2 ||
      SCAN_CYCLES < 2) begin : g_bad
    $error("event_recorder_module: NUM_CH 1..16, MS/SCAN_CYCLES >= 2");
  end

  // ==========================================================================
  // Register strobes
  logic mskWr, ctlWr, timeWr, statRd, chatRd;
  assign mskWr  = busWr && (busAddr == event_recorder_pkg::ADDR_MASK);
  assign ctlWr  = busWr && (busAddr == event_recorder_pkg::ADDR_CTRL);
  assign timeWr = busWr && (busAddr == event_recorder_pkg::ADDR_TIME);
  assign statRd = busRd && (busAddr == event_recorder_pkg::ADDR_STATUS);
  assign chatRd = busRd && (busAddr == event_recorder_pkg::ADDR_CHATTER);

  // ==========================================================================
  // Scan period, millisecond tick and time of day
  logic [SC_W-1:0]   scanCnt_q, scanCnt_d;
  logic [MS_W-1:0]   msCnt_q, msCnt_d;
  logic [15:0]       time_q, time_d;
  logic              scanTick, msTick;

  assign scanTick = (scanCnt_q == SCAN_LAST);
  assign msTick   = (msCnt_q == MS_W'(MS_CYCLES - 1));

  // Time write also restarts the prescaler so all modules tick together
  always_comb begin
    scanCnt_d = scanTick ? '0 : SC_W'(scanCnt_q + 1'b1);
    msCnt_d   = (timeWr || msTick) ? '0 : MS_W'(msCnt_q + 1'b1);
    time_d    = time_q;
    if (timeWr) begin
      time_d = busWrData;
    end else if (msTick) begin
      time_d = 16'(time_q + 1'b1);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scanCnt_q <= '0;
      msCnt_q   <= '0;
      time_q    <= event_recorder_pkg::TIME_RST;
    end else begin
      scanCnt_q <= scanCnt_d;
      msCnt_q   <= msCnt_d;
      time_q    <= time_d;
    end
  end

  // ==========================================================================
  // Control registers
  logic [NUM_CH-1:0] mask_q, mask_d;
  logic [15:0]       ctrl_q, ctrl_d;
  logic              policyCount;

  always_comb begin
    mask_d = mskWr ? busWrData[NUM_CH-1:0] : mask_q;
    ctrl_d = ctlWr ? busWrData : ctrl_q;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_q <= event_recorder_pkg::MASK_RST[NUM_CH-1:0];
      ctrl_q <= event_recorder_pkg::CTRL_RST;
    end else begin
      mask_q <= mask_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign policyCount = ctrl_q[event_recorder_pkg::CTRL_POLICY_BIT];

  // ==========================================================================
  // Debounce: a change must persist across the full filter window
  logic [DEB_W-1:0]  debCnt_q [NUM_CH];
  logic [DEB_W-1:0]  debCnt_d [NUM_CH];
  logic [NUM_CH-1:0] stable_q, stable_d, chg;

  // Sampled once per scan, so pulses between scans are also ignored
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      debCnt_d[i] = debCnt_q[i];
      stable_d[i] = stable_q[i];
      chg[i]      = 1'b0;
      if (scanTick) begin
        if (fieldIn[i] == stable_q[i]) begin
          debCnt_d[i] = '0;
        end else if (DEB_W'(debCnt_q[i] + 1'b1) == DEB_LIMIT) begin
          debCnt_d[i] = '0;
          stable_d[i] = fieldIn[i];
          chg[i]      = 1'b1;
        end else begin
          debCnt_d[i] = DEB_W'(debCnt_q[i] + 1'b1);
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stable_q <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        debCnt_q[i] <= '0;
      end
    end else begin
      stable_q <= stable_d;
      debCnt_q <= debCnt_d;
    end
  end

  // ==========================================================================
  // Chatter detection, both policies tracked, selected one applied
  logic [AGE_W-1:0]  age_q [NUM_CH];
  logic [AGE_W-1:0]  age_d [NUM_CH];
  logic [CNT_W-1:0]  nChg_q [NUM_CH];
  logic [CNT_W-1:0]  nChg_d [NUM_CH];
  logic [NUM_CH-1:0] chat_q, chat_d;
  logic              swap;

  // Set wins over the clear-on-read of the chatter register
  always_comb begin
    chat_d = chatRd ? '0 : chat_q;
    for (int i = 0; i < NUM_CH; i++) begin
      age_d[i]  = age_q[i];
      nChg_d[i] = swap ? '0 : nChg_q[i];
      if (msTick && age_q[i] != AGE_LIMIT) begin
        age_d[i] = AGE_W'(age_q[i] + 1'b1);
      end
      if (chg[i]) begin
        age_d[i] = '0;
        if (nChg_d[i] != CNT_LIMIT) begin
          nChg_d[i] = CNT_W'(nChg_d[i] + 1'b1);
        end
        if (policyCount) begin
          if (nChg_d[i] == CNT_LIMIT) begin
            chat_d[i] = 1'b1;
          end
        end else if (age_q[i] != AGE_LIMIT) begin
          chat_d[i] = 1'b1;
        end
      end
    end
  end

  // Age starts saturated so a first change is never chatter
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      chat_q <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        age_q[i]  <= AGE_LIMIT;
        nChg_q[i] <= '0;
      end
    end else begin
      chat_q <= chat_d;
      age_q  <= age_d;
      nChg_q <= nChg_d;
    end
  end

  // ==========================================================================
  // Pending changes of enabled channels, emitted lowest channel first
  rec_stream_if #(.W(event_recorder_pkg::REC_W)) recIn ();
  rec_stream_if #(.W(event_recorder_pkg::REC_W)) recOut ();
  logic [NUM_CH-1:0] pend_q, pend_d, pick;
  logic [3:0]        pickId;
  logic [15:0]       idWord;

  function automatic logic [3:0] lowestSet(input logic [NUM_CH-1:0] v);
    logic [3:0] r;
    r = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  assign pickId = lowestSet(pend_q);
  assign pick   = NUM_CH'(1) << pickId;

  // Channel id, new state and chatter flag form the identifier word
  always_comb begin
    idWord                                  = '0;
    idWord[event_recorder_pkg::ID_W-1:0]    = pickId;
    idWord[event_recorder_pkg::ID_STATE_BIT] = stable_q[pickId];
    idWord[event_recorder_pkg::ID_CHAT_BIT]  = chat_q[pickId];
  end

  assign recIn.valid = |pend_q;
  assign recIn.data  = {idWord, time_q};

  // A new change on the channel being emitted stays pending
  always_comb begin
    pend_d = pend_q;
    if (recIn.valid && recIn.ready) begin
      pend_d = pend_q & ~pick;
    end
    pend_d = pend_d | (chg & mask_q);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end

  rec_fifo #(
    .WIDTH (event_recorder_pkg::REC_W),
    .DEPTH (event_recorder_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk   (sys_clk),
    .rst_n (arst_n),
    .inp   (recIn),
    .outp  (recOut)
  );

  // ==========================================================================
  // Two banks of 32 records; each record is an id word and a time word
  logic [31:0]     mem [2][event_recorder_pkg::BUF_EVENTS];
  logic            wrBank_q, wrBank_d;
  logic [EV_W-1:0] wrCnt_q, wrCnt_d;
  logic [EV_W-1:0] frzCnt_q, frzCnt_d;
  logic            ovf_q, ovf_d;
  logic            memWe;

  assign swap         = statRd;
  // Writer stalls during the swap so no record straddles it
  assign recOut.ready = !swap;
  assign memWe        = recOut.valid && recOut.ready && (wrCnt_q != EV_LIMIT);

  always_comb begin
    wrBank_d = wrBank_q;
    wrCnt_d  = wrCnt_q;
    frzCnt_d = frzCnt_q;
    ovf_d    = ovf_q;
    if (swap) begin
      wrBank_d = !wrBank_q;
      frzCnt_d = wrCnt_q;
      wrCnt_d  = '0;
      ovf_d    = 1'b0;
    end else if (memWe) begin
      wrCnt_d = EV_W'(wrCnt_q + 1'b1);
    end else if (recOut.valid) begin
      ovf_d = 1'b1; // Full bank: record is dropped
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrBank_q <= 1'b0;
      wrCnt_q  <= '0;
      frzCnt_q <= '0;
      ovf_q    <= 1'b0;
    end else begin
      wrBank_q <= wrBank_d;
      wrCnt_q  <= wrCnt_d;
      frzCnt_q <= frzCnt_d;
      ovf_q    <= ovf_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (memWe) begin
      mem[wrBank_q][wrCnt_q[EV_W-2:0]] <= recOut.data;
    end
  end

  // ==========================================================================
  // Read data path, answered one cycle after the strobe
  logic [15:0] rdData_d, rdData_q;
  logic [4:0]  rdRec;
  logic [31:0] rdWord;

  assign rdRec  = busAddr[5:1];
  assign rdWord = mem[!wrBank_q][rdRec];

  // Unmapped addresses and unwritten records read as zero
  always_comb begin
    rdData_d = '0;
    if (busRd) begin
      if (busAddr >= event_recorder_pkg::ADDR_BUF_BASE) begin
        if (EV_W'(rdRec) < frzCnt_q) begin
          rdData_d = busAddr[0] ? rdWord[15:0] : rdWord[31:16];
        end
      end else begin
        unique case (busAddr)
          event_recorder_pkg::ADDR_MASK:    rdData_d = 16'(mask_q);
          event_recorder_pkg::ADDR_CTRL:    rdData_d = ctrl_q;
          event_recorder_pkg::ADDR_TIME:    rdData_d = time_q;
          event_recorder_pkg::ADDR_STATUS: begin
            rdData_d      = 16'({wrCnt_q, 1'b0});
            rdData_d[event_recorder_pkg::STAT_OVF_BIT]  = ovf_q;
            rdData_d[event_recorder_pkg::STAT_BANK_BIT] = wrBank_q;
          end
          event_recorder_pkg::ADDR_CHATTER: rdData_d = 16'(chat_q);
          event_recorder_pkg::ADDR_INPUTS:  rdData_d = 16'(stable_q);
          default:                          rdData_d = '0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= '0;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  assign busRdData = rdData_q;

endmodule // event_recorder_module

// file: event_recorder_monitor.sv
// Bus-side assertions for the event recorder, bound to its top module
`timescale 1ns/1ps
module event_recorder_monitor #(
  parameter int NUM_CH    = 16,
  parameter int MS_CYCLES = 25000
) (
  input wire logic              sys_clk,   // System clock
  input wire logic              arst_n,    // Async reset, active low
  input wire logic [NUM_CH-1:0] fieldIn,   // Field inputs
  input wire logic [6:0]        busAddr,   // Word address
  input wire logic [15:0]       busWrData, // Write data
  input wire logic              busWr,     // Write strobe
  input wire logic              busRd,     // Read strobe
  input wire logic [15:0]       busRdData  // Read data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // ==========================================================================
  // Helper state
  logic        statRd_q; // Status data stands this cycle
  logic        bank_q;   // Bank bit of the last status read
  logic [6:0]  count_q;  // Words in the frozen bank
  logic [15:0] chMask;   // Implemented channel bits
  assign chMask = 16'((17'h1 << NUM_CH) - 17'h1);

  // Bank starts at one so the first status read must name bank zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      statRd_q <= 1'b0;
      bank_q   <= 1'b1;
      count_q  <= 7'h00;
    end else begin
      statRd_q <= busRd && busAddr == event_recorder_pkg::ADDR_STATUS;
      if (statRd_q) begin
        bank_q  <= busRdData[event_recorder_pkg::STAT_BANK_BIT];
        count_q <= busRdData[6:0];
      end
    end
  end

  // ==========================================================================
  // Bus answers
  a_idle_data_zero: assert property (!$past(busRd) |-> busRdData == 16'h0000)
    else $error("read data not zero outside the answer cycle");
  a_unmapped_reads_zero: assert property (busRd && busAddr > 7'h05 &&
    busAddr < 7'h40 |=> busRdData == 16'h0000)
    else $error("unmapped read gave data");
  a_mask_read_back: assert property (busWr && busAddr == 7'h00 ##1
    busRd && busAddr == 7'h00 |=> busRdData == ($past(busWrData, 2) & chMask))
    else $error("tagging mask read back wrong");
  a_policy_read_back: assert property (busWr && busAddr == 7'h01 ##1
    busRd && busAddr == 7'h01 |=> busRdData == $past(busWrData, 2))
    else $error("control word read back wrong");
  a_time_load_back: assert property (busWr && busAddr == 7'h02 ##1
    busRd && busAddr == 7'h02 |=> busRdData == $past(busWrData, 2))
    else $error("loaded time not read back");
  a_status_word_form: assert property (busRd && busAddr == 7'h03 |=>
    busRdData[15:10] == 6'h00 && !busRdData[7] && !busRdData[0] &&
    busRdData[6:0] <= 7'h40)
    else $error("status word malformed");
  a_bank_swap_each: assert property (statRd_q |->
    busRdData[event_recorder_pkg::STAT_BANK_BIT] != bank_q)
    else $error("status read did not swap banks");
  a_beyond_count_zero: assert property (busRd && busAddr >= 7'h40 &&
    !statRd_q && (busAddr - 7'h40) >= count_q |=> busRdData == 16'h0000)
    else $error("word beyond frozen count not zero");
  a_id_word_form: assert property (busRd && busAddr >= 7'h40 &&
    !busAddr[0] |=> busRdData[15:6] == 10'h000 &&
    32'(busRdData[3:0]) < NUM_CH)
    else $error("identifier word malformed");
endmodule // event_recorder_monitor

bind event_recorder_module event_recorder_monitor #(
  .NUM_CH(NUM_CH), .MS_CYCLES(MS_CYCLES)
) i_monitor (
  .sys_clk(sys_clk), .arst_n(arst_n), .fieldIn(fieldIn),
  .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr),
  .busRd(busRd), .busRdData(busRdData)
);

// file: ctrl_model.sv
// Process controller model driving the recorder's register bus
`timescale 1ns/1ps
module ctrl_model (
  input  wire logic        sys_clk,   // System clock
  output logic      [6:0]  busAddr,   // Word address
  output logic      [15:0] busWrData, // Write data
  output logic             busWr,     // Write strobe
  output logic             busRd      // Read strobe
);
  // ==========================================================================
  // Bus cycle
  initial begin
    busAddr   = 7'h00;
    busWrData = 16'h0000;
    busWr     = 1'b0;
    busRd     = 1'b0;
  end

  // Called just after an edge; every signal is set once, then one edge passes
  task automatic access(input logic wr, input logic rd,
                        input logic [6:0] a, input logic [15:0] d);
    busWr     <= wr;
    busRd     <= rd;
    busAddr   <= a;
    busWrData <= d;
    @(posedge sys_clk);
  endtask
endmodule // ctrl_model

// file: event_recorder_module_test.sv
// Self-checking bench for the event recorder
`timescale 1ns/1ps
module event_recorder_module_test;
  localparam int          MS = 64;       // Shortened ms; a scan is MS / 8
  localparam logic [15:0] T1 = 16'h0A5C; // Stamp held during events
  logic        sys_clk;
  logic        arst_n;
  logic [15:0] fieldIn;
  logic [6:0]  busAddr;
  logic [15:0] busWrData;
  logic        busWr;
  logic        busRd;
  logic [15:0] busRdData;
  logic        rdSeen;
  logic [15:0] expQ[$];
  logic [15:0] rndA;
  int          badCount;
  int          testsRun;

  event_recorder_module #(
    .NUM_CH(16), .MS_CYCLES(MS), .SCAN_CYCLES(MS / 8)) i_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .fieldIn(fieldIn),
    .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr),
    .busRd(busRd), .busRdData(busRdData));
  ctrl_model i_ctrl (
    .sys_clk(sys_clk), .busAddr(busAddr), .busWrData(busWrData),
    .busWr(busWr), .busRd(busRd));

  // ==========================================================================
  // Clock, report and compare
  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;

  task automatic stopTest();
    $display("Counts: %0d compared, %0d mismatched", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cmpWord(input logic [15:0] exp, input logic [15:0] got);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("MISMATCH at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  // Read data stands only in the cycle after the strobe: look mid-cycle
  always @(posedge sys_clk) rdSeen <= busRd;
  always @(negedge sys_clk) begin
    if (rdSeen === 1'b1) begin
      cmpWord(expQ.pop_front(), busRdData);
    end
  end

  // ==========================================================================
  // Bus wrappers; idle cycles put inverted values on the released lines
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    i_ctrl.access(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    expQ.push_back(exp);
    i_ctrl.access(1'b0, 1'b1, a, ~busWrData);
  endtask
  task automatic idle(input int n);
    repeat (n) i_ctrl.access(1'b0, 1'b0, ~busAddr, ~busWrData);
  endtask
  // Time reloaded every 32 cycles, so the millisecond never ticks
  task automatic holdTime(input int n);
    repeat (n) begin
      wr(event_recorder_pkg::ADDR_TIME, T1);
      idle(31);
    end
  endtask

  // Hang guard: a full run takes about 3k cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    badCount++;
    $display("Timeout reached");
    stopTest();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(41374));
    arst_n   = 1'b0;
    fieldIn  = 16'h0000;
    badCount = 0;
    testsRun = 0;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(event_recorder_pkg::ADDR_MASK, event_recorder_pkg::MASK_RST);
    rd(event_recorder_pkg::ADDR_CTRL, event_recorder_pkg::CTRL_RST);
    rd(event_recorder_pkg::ADDR_INPUTS, 16'h0000);
    rd(event_recorder_pkg::ADDR_STATUS, 16'h0000);
    rd(event_recorder_pkg::ADDR_BUF_BASE, 16'h0000);
    idle(1);
    $display("Reset values done");
    // Random words, back to back; unmapped writes must leave the mask alone
    rndA = 16'($urandom());
    wr(event_recorder_pkg::ADDR_MASK, rndA);
    rd(event_recorder_pkg::ADDR_MASK, rndA);
    wr(event_recorder_pkg::ADDR_CTRL, ~rndA);
    rd(event_recorder_pkg::ADDR_CTRL, ~rndA);
    wr(7'h06 + 7'($urandom_range(57)), ~rndA);
    rd(7'h06 + 7'($urandom_range(57)), 16'h0000);
    rd(event_recorder_pkg::ADDR_MASK, rndA);
    idle(1);
    $display("Register access done");
    wr(event_recorder_pkg::ADDR_TIME, T1 - 16'h0003);
    rd(event_recorder_pkg::ADDR_TIME, T1 - 16'h0003);
    idle(3 * MS + 6);
    rd(event_recorder_pkg::ADDR_TIME, T1);
    wr(event_recorder_pkg::ADDR_CTRL, event_recorder_pkg::CTRL_RST);
    wr(event_recorder_pkg::ADDR_MASK, 16'h000D);
    idle(1);
    $display("Time base done");
    // Ch1 untagged, ch3 a 28-scan glitch of 3.5 ms, under the 4 ms limit
    fieldIn <= 16'h000F;
    holdTime(7);
    fieldIn <= 16'h0007;
    holdTime(12);
    rd(event_recorder_pkg::ADDR_INPUTS, 16'h0007);
    rd(event_recorder_pkg::ADDR_CHATTER, 16'h0000);
    rd(event_recorder_pkg::ADDR_STATUS, 16'h0204);
    rd(event_recorder_pkg::ADDR_BUF_BASE, 16'h0010);
    rd(event_recorder_pkg::ADDR_BUF_BASE + 7'h01, T1);
    rd(event_recorder_pkg::ADDR_BUF_BASE + 7'h02, 16'h0012);
    rd(event_recorder_pkg::ADDR_BUF_BASE + 7'h03, T1);
    rd(event_recorder_pkg::ADDR_BUF_BASE + 7'h04, 16'h0000);
    rd(event_recorder_pkg::ADDR_STATUS, 16'h0000);
    rd(event_recorder_pkg::ADDR_BUF_BASE, 16'h0000);
    idle(3);
    $display("Event recording done");
    // Ch0 falls again with the clock held: too soon, so chatter
    fieldIn <= 16'h0006;
    holdTime(12);
    rd(event_recorder_pkg::ADDR_CHATTER, 16'h0001);
    rd(event_recorder_pkg::ADDR_CHATTER, 16'h0000);
    rd(event_recorder_pkg::ADDR_STATUS, 16'h0202);
    rd(event_recorder_pkg::ADDR_BUF_BASE, 16'h0020);
    $display("Rate chatter done");
    // Count policy: three fast changes pass, the fourth is chatter
    wr(event_recorder_pkg::ADDR_CTRL, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      fieldIn <= {13'h0000, ~fieldIn[2], 2'b10};
      holdTime(12);
      if (i == 2) rd(event_recorder_pkg::ADDR_CHATTER, 16'h0000);
    end
    rd(event_recorder_pkg::ADDR_CHATTER, 16'h0004);
    rd(event_recorder_pkg::ADDR_STATUS, 16'h0008);
    rd(event_recorder_pkg::ADDR_BUF_BASE + 7'h04, 16'h0002);
    rd(event_recorder_pkg::ADDR_BUF_BASE + 7'h06, 16'h0032);
    $display("Count chatter done");
    stopTest();
  end
endmodule // event_recorder_module_test
